/* File: verilog/atw_core.sv */
`timescale 1ns/100ps
// Summary of operation
// [R1] set-block-count sets busy and takes sector count as sectors per block
// [R2] valid supported block count is stored and enables multi-sector commands
// [R3] zero block count disables multi-sector commands
// [R4] power-on, hard reset, soft reset (unless revert off) disable multi mode
// [R5] sleep command: busy, enter sleep, clear busy, interrupt
// [R6] any later command wakes the device; no reset needed
// [R7] idle timer of five milliseconds puts the device to sleep
// [R8] both standby commands: busy, sleep, clear busy, interrupt at once
// [R9] buffer write takes 512 bytes by PIO into the sector buffer
// [R10] DMA write moves 1 to 256 sectors, zero meaning 256
// [R11] DMA write: busy, then data request, DMA request while accepting
// [R12] host acknowledges DMA and strobes once per 16-bit word
// [R13] DMA write interrupts only on completion or unrecoverable error
// [R14] error leaves failing sector address, success leaves last sector address
// [R15] DMA write aborted when 8-bit transfer mode is on
// [R16] 28-bit start address over address registers, zero count is 256
// [R17] good multi-sector write ends with busy, fault, request, error clear
// [R18] bad address sets not-found; error set with any error bit; fault bit
// [R19] transfer CRC error or unreported bad address sets abort
// [R20] each block starts with data request and interrupt; last block partial
// [R21] multi-sector write while multi mode off is aborted
// [R22] write error posted after its block; no further blocks
// [R23] unsupported nonzero block count aborts, old setting kept
module atw_core
	import atw_pkg::*;
#(
	parameter int IDLE_COUNT = IDLE_CYCLES
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic resetn_i,
	// host pins
	input wire logic cs0_n_i,
	input wire logic [2:0] addr_i,
	input wire logic iord_n_i,
	input wire logic iowr_n_i,
	input wire logic dmack_n_i,
	input wire logic [15:0] data_i,
	output logic [15:0] data_o,
	output logic data_oe_o,
	output logic dmarq_o,
	output logic intrq_o,
	// on-chip control levels
	input wire logic soft_reset_i,
	input wire logic revert_off_i,
	input wire logic eight_bit_i,
	input wire logic crc_err_i,
	input wire logic [27:0] capacity_i,
	// media back end
	output logic media_req_o,
	output logic [27:0] media_lba_o,
	input wire logic media_done_i,
	input wire logic media_err_i,
	input wire logic media_fault_i,
	input wire logic [7:0] media_rd_addr_i,
	output logic [15:0] media_rd_data_o,
	output logic sleep_o
);
	// ==========================================
	// reset and pin synchronisers
	logic [1:0] rst_sync_r;
	logic rst_n_r;
	logic [22:0] pin_s1_r;
	logic [22:0] pin_s2_r;
	logic iowr_q_r;
	logic iord_q_r;
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n_r = rst_sync_r[1];
	always_ff @(posedge core_clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pin_s1_r <= 23'h7FFFFF;
			pin_s2_r <= 23'h7FFFFF;
			iowr_q_r <= 1'b1;
			iord_q_r <= 1'b1;
		end else begin
			pin_s1_r <= {cs0_n_i, iord_n_i, iowr_n_i, dmack_n_i, addr_i, data_i};
			pin_s2_r <= pin_s1_r;
			iowr_q_r <= pin_s2_r[20];
			iord_q_r <= pin_s2_r[21];
		end
	end
	logic cs0_n_s;
	logic iord_n_s;
	logic dmack_n_s;
	logic [2:0] addr_s;
	logic [15:0] data_s;
	logic wr_rise;
	logic rd_fall;
	assign cs0_n_s = pin_s2_r[22];
	assign iord_n_s = pin_s2_r[21];
	assign dmack_n_s = pin_s2_r[19];
	assign addr_s = pin_s2_r[18:16];
	assign data_s = pin_s2_r[15:0];
	// strobe edge taken at release so the data has settled
	assign wr_rise = pin_s2_r[20] && !iowr_q_r;
	assign rd_fall = !iord_n_s && iord_q_r;
	// ==========================================
	// state and shared signals
	atw_state_t state_r;
	logic [7:0] cmd_r;
	logic [7:0] count_r;
	logic [7:0] feature_r;
	logic [7:0] lo_r;
	logic [7:0] mid_r;
	logic [7:0] hi_r;
	logic [7:0] dev_r;
	logic [7:0] multi_cnt_r;
	logic multi_en_r;
	logic [7:0] word_cnt_r;
	logic [8:0] sect_left_r;
	logic [8:0] blk_left_r;
	logic blk_err_r;
	logic [7:0] error_r;
	logic df_r;
	logic sleep_r;
	logic intrq_r;
	logic [15:0] buf_mem [0:255];
	logic cmd_wr;
	logic tf_wr;
	logic word_in;
	logic sector_full;
	logic fin_ok;
	logic fin_err;
	logic set_abrt;
	logic set_idnf;
	logic set_df;
	logic adv_addr;
	logic blk_start;
	logic sec_err;
	logic range_bad;
	logic count_ok;
	logic [8:0] req_sect;
	logic [8:0] next_blk;
	logic [28:0] lba_end;
	logic [27:0] lba;
	assign lba = {dev_r[3:0], hi_r, mid_r, lo_r};
	assign cmd_wr = wr_rise && !cs0_n_s && addr_s == OFS_COMMAND && state_r == ST_IDLE;
	assign tf_wr = wr_rise && !cs0_n_s && addr_s != OFS_COMMAND && addr_s != OFS_DATA
		&& state_r == ST_IDLE;
	// [R9] [R12] one word per strobe
	assign word_in = (wr_rise && !cs0_n_s && addr_s == OFS_DATA && state_r == ST_PIO_IN)
		|| (wr_rise && !dmack_n_s && state_r == ST_DMA_IN);
	assign sector_full = word_in && word_cnt_r == LAST_WORD;
	// [R10] [R16] zero count means 256
	assign req_sect = (count_r == 8'h00) ? FULL_COUNT : {1'b0, count_r};
	assign lba_end = {1'b0, lba} + {20'h00000, req_sect} - 29'h1;
	assign range_bad = lba_end >= {1'b0, capacity_i};
	// supported block sizes: powers of two up to the largest block
	assign count_ok = count_r <= BLOCK_MAX && (count_r & (count_r - 8'h01)) == 8'h00;
	assign sec_err = !blk_err_r && (media_err_i || media_fault_i);
	always_comb begin
		fin_ok = 1'b0;
		fin_err = 1'b0;
		set_abrt = 1'b0;
		set_idnf = 1'b0;
		set_df = 1'b0;
		adv_addr = 1'b0;
		blk_start = 1'b0;
		next_blk = (sect_left_r - 9'h1 < {1'b0, multi_cnt_r}) ? sect_left_r - 9'h1
			: {1'b0, multi_cnt_r};
		case (state_r)
			ST_EXEC: begin
				case (cmd_r)
					CMD_SET_MULTI: begin
						// [R23] unsupported size aborts
						fin_ok = count_ok;
						fin_err = !count_ok;
						set_abrt = !count_ok;
					end
					CMD_SLEEP, CMD_STANDBY, CMD_STANDBY_NOW, CMD_WRITE_BUF: begin
						fin_ok = cmd_r != CMD_WRITE_BUF;
					end
					CMD_WRITE_DMA: begin
						// [R15] no DMA write in 8-bit mode
						fin_err = eight_bit_i || range_bad;
						set_abrt = eight_bit_i;
						// [R18] unreachable address
						set_idnf = !eight_bit_i && range_bad;
					end
					CMD_WRITE_MULTI: begin
						// [R21] multi mode must be on
						fin_err = !multi_en_r || range_bad;
						set_abrt = !multi_en_r;
						set_idnf = multi_en_r && range_bad;
						// [R20] first block request
						blk_start = !fin_err;
					end
					default: begin
						fin_err = 1'b1;
						set_abrt = 1'b1;
					end
				endcase
			end
			ST_PIO_IN: begin
				fin_ok = sector_full && cmd_r == CMD_WRITE_BUF;
			end
			ST_DMA_IN: begin
				// [R19] transfer CRC error aborts
				fin_err = crc_err_i;
				set_abrt = crc_err_i;
			end
			ST_WAIT: begin
				if (media_done_i || blk_err_r) begin
					set_df = media_fault_i && !blk_err_r;
					if (cmd_r == CMD_WRITE_DMA) begin
						// [R14] stop at failing sector
						fin_err = sec_err;
						set_abrt = sec_err;
						fin_ok = !sec_err && sect_left_r == 9'h1;
						adv_addr = !sec_err && sect_left_r != 9'h1;
					end else if (blk_left_r == 9'h1) begin
						// [R22] error posted at block end
						fin_err = blk_err_r || sec_err;
						set_abrt = blk_err_r || sec_err;
						fin_ok = !fin_err && sect_left_r == 9'h1;
						blk_start = !fin_err && sect_left_r != 9'h1;
						adv_addr = blk_start;
					end else begin
						adv_addr = !blk_err_r && !sec_err;
					end
				end
			end
			default: begin
			end
		endcase
	end
	// ==========================================
	// command sequencer
	always_ff @(posedge core_clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			state_r <= ST_IDLE;
			cmd_r <= 8'h00;
			word_cnt_r <= 8'h00;
			sect_left_r <= 9'h000;
			blk_left_r <= 9'h000;
			blk_err_r <= 1'b0;
		end else if (soft_reset_i) begin
			state_r <= ST_IDLE;
			blk_err_r <= 1'b0;
		end else begin
			if (word_in) begin
				word_cnt_r <= word_cnt_r + 8'h01;
			end
			case (state_r)
				ST_IDLE: begin
					// [R1] busy on command
					if (cmd_wr) begin
						cmd_r <= data_s[7:0];
						state_r <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					word_cnt_r <= 8'h00;
					sect_left_r <= req_sect;
					blk_err_r <= 1'b0;
					blk_left_r <= (req_sect < {1'b0, multi_cnt_r}) ? req_sect
						: {1'b0, multi_cnt_r};
					if (fin_ok || fin_err) begin
						state_r <= ST_IDLE;
					end else if (cmd_r == CMD_WRITE_DMA) begin
						state_r <= ST_DMA_IN;
					end else begin
						state_r <= ST_PIO_IN;
					end
				end
				ST_PIO_IN, ST_DMA_IN: begin
					if (fin_ok || fin_err) begin
						state_r <= ST_IDLE;
					end else if (sector_full) begin
						state_r <= ST_COMMIT;
					end
				end
				ST_COMMIT: begin
					state_r <= ST_WAIT;
				end
				ST_WAIT: begin
					if (media_done_i || blk_err_r) begin
						sect_left_r <= sect_left_r - 9'h1;
						blk_left_r <= blk_start ? next_blk : blk_left_r - 9'h1;
						if (sec_err) begin
							blk_err_r <= 1'b1;
						end
						if (fin_ok || fin_err) begin
							state_r <= ST_IDLE;
						end else if (cmd_r == CMD_WRITE_DMA) begin
							state_r <= ST_DMA_IN;
						end else begin
							state_r <= ST_PIO_IN;
						end
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end
	// ==========================================
	// sector buffer and media port
	always_ff @(posedge core_clk_i) begin
		if (word_in) begin
			buf_mem[word_cnt_r] <= data_s;
		end
		media_rd_data_o <= buf_mem[media_rd_addr_i];
	end
	// errored block sectors are not written but still drained from the host
	always_ff @(posedge core_clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			media_req_o <= 1'b0;
			dmarq_o <= 1'b0;
		end else begin
			media_req_o <= state_r == ST_COMMIT && !blk_err_r;
			// [R11] request while able to accept
			dmarq_o <= state_r == ST_DMA_IN && !sector_full && !fin_err;
		end
	end
	assign media_lba_o = lba;
	// ==========================================
	// task-file registers
	always_ff @(posedge core_clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			count_r <= 8'h00;
			feature_r <= 8'h00;
			lo_r <= 8'h00;
			mid_r <= 8'h00;
			hi_r <= 8'h00;
			dev_r <= 8'h00;
		end else if (tf_wr) begin
			case (addr_s)
				OFS_FEATURE: feature_r <= data_s[7:0];
				OFS_COUNT: count_r <= data_s[7:0];
				OFS_ADDR_LO: lo_r <= data_s[7:0];
				OFS_ADDR_MID: mid_r <= data_s[7:0];
				OFS_ADDR_HI: hi_r <= data_s[7:0];
				default: dev_r <= data_s[7:0];
			endcase
		end else if (adv_addr) begin
			// [R14] advance only between good sectors
			{dev_r[3:0], hi_r, mid_r, lo_r} <= lba + 28'h1;
		end
	end
	// ==========================================
	// block-count setting
	always_ff @(posedge core_clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			// [R4] off after power-on and hard reset
			multi_en_r <= 1'b0;
			multi_cnt_r <= MULTI_RST;
		end else if (soft_reset_i && !revert_off_i) begin
			multi_en_r <= 1'b0;
			multi_cnt_r <= MULTI_RST;
		end else if (state_r == ST_EXEC && cmd_r == CMD_SET_MULTI && count_ok) begin
			// [R2] [R3] load size, zero disables
			multi_en_r <= count_r != 8'h00;
			multi_cnt_r <= count_r;
		end
	end
	// ==========================================
	// error and fault bits
	always_ff @(posedge core_clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			error_r <= ERROR_RST;
			df_r <= 1'b0;
		end else if (state_r == ST_EXEC) begin
			error_r <= {3'h0, set_idnf, 1'b0, set_abrt, 2'h0};
			df_r <= 1'b0;
		end else begin
			// [R18] [R19] accumulate abort and fault bits
			error_r[ER_ABRT] <= error_r[ER_ABRT] || set_abrt;
			df_r <= df_r || set_df;
		end
	end
	// ==========================================
	// interrupt and read-back
	always_ff @(posedge core_clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			intrq_r <= 1'b0;
			data_o <= 16'h0000;
			data_oe_o <= 1'b0;
		end else begin
			// [R13] completion and block start only; a set beats a status read
			if (fin_ok || fin_err || blk_start) begin
				intrq_r <= 1'b1;
			end else if (rd_fall && !cs0_n_s && addr_s == OFS_COMMAND) begin
				intrq_r <= 1'b0;
			end
			data_oe_o <= !iord_n_s && !cs0_n_s;
			case (addr_s)
				OFS_FEATURE: data_o <= {8'h00, error_r};
				OFS_COUNT: data_o <= {8'h00, count_r};
				OFS_ADDR_LO: data_o <= {8'h00, lo_r};
				OFS_ADDR_MID: data_o <= {8'h00, mid_r};
				OFS_ADDR_HI: data_o <= {8'h00, hi_r};
				OFS_DEVICE: data_o <= {8'h00, dev_r};
				// [R17] status built from live state
				OFS_COMMAND: data_o <= {8'h00, state_r == ST_EXEC || state_r == ST_COMMIT
					|| state_r == ST_WAIT, 1'b1, df_r, 1'b0,
					state_r == ST_PIO_IN || state_r == ST_DMA_IN, 2'h0, error_r != 8'h00};
				default: data_o <= 16'h0000;
			endcase
		end
	end
	assign intrq_o = intrq_r;
	// ==========================================
	// power state and idle timer
	logic [31:0] idle_cnt_r;
	always_ff @(posedge core_clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			sleep_r <= 1'b0;
			idle_cnt_r <= 32'h0;
		end else begin
			if (state_r != ST_IDLE || sleep_r || wr_rise) begin
				idle_cnt_r <= 32'h0;
			end else begin
				idle_cnt_r <= idle_cnt_r + 32'h1;
			end
			// [R5] [R8] sleep commands
			if (state_r == ST_EXEC && fin_ok && (cmd_r == CMD_SLEEP
				|| cmd_r == CMD_STANDBY || cmd_r == CMD_STANDBY_NOW)) begin
				sleep_r <= 1'b1;
			// [R7] idle expiry
			end else if (idle_cnt_r == 32'(IDLE_COUNT - 1)) begin
				sleep_r <= 1'b1;
			// [R6] wake on command
			end else if (cmd_wr) begin
				sleep_r <= 1'b0;
			end
		end
	end
	assign sleep_o = sleep_r;
	// ==========================================
	// checks
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_r);
	sequence sleep_cmd_s;
		state_r == ST_EXEC && (cmd_r == CMD_SLEEP || cmd_r == CMD_STANDBY);
	endsequence
	sequence dma_run_s;
		(state_r == ST_DMA_IN && !sector_full && !crc_err_i)[*2];
	endsequence
	busy_on_cmd_a: assert property (cmd_wr |=> state_r == ST_EXEC ##1 state_r != ST_EXEC) // [R1]
		else $error("command not executed after busy");
	multi_load_a: assert property (state_r == ST_EXEC && cmd_r == CMD_SET_MULTI && count_ok
		&& !soft_reset_i |=> multi_cnt_r == $past(count_r)) // [R2]
		else $error("block count not loaded");
	zero_count_a: assert property (state_r == ST_EXEC && cmd_r == CMD_SET_MULTI
		&& count_r == 8'h00 |=> !multi_en_r) // [R3]
		else $error("zero count left multi mode on");
	sleep_entry_a: assert property (sleep_cmd_s |=> sleep_r && intrq_r
		&& state_r == ST_IDLE) // [R5]
		else $error("sleep command did not sleep and interrupt");
	wake_cmd_a: assert property (cmd_wr && sleep_r |=> !sleep_r) // [R6]
		else $error("command did not wake device");
	dma_req_a: assert property (dma_run_s |-> dmarq_o) // [R11]
		else $error("dma request missing");
	dma_no_irq_a: assert property (state_r == ST_WAIT && cmd_r == CMD_WRITE_DMA
		&& !fin_ok && !fin_err && !intrq_r |=> !intrq_r) // [R13]
		else $error("per-sector dma interrupt");
	dma_eight_a: assert property (state_r == ST_EXEC && cmd_r == CMD_WRITE_DMA && eight_bit_i
		&& !soft_reset_i |=> error_r[ER_ABRT] && state_r == ST_IDLE) // [R15]
		else $error("dma write not aborted in 8-bit mode");
	multi_off_a: assert property (state_r == ST_EXEC && cmd_r == CMD_WRITE_MULTI && !multi_en_r
		|=> error_r[ER_ABRT] && !dmarq_o ##1 state_r == ST_IDLE) // [R21]
		else $error("write multiple accepted while disabled");
	good_end_a: assert property (fin_ok && cmd_r == CMD_WRITE_MULTI && !soft_reset_i
		|=> state_r == ST_IDLE && error_r == 8'h00 && !df_r) // [R17]
		else $error("bad status after good write multiple");
endmodule // atw_core

/* File: pkg/atw_pkg.sv */
package atw_pkg;
	// ==========================================
	// task-file offsets
	localparam logic [2:0] OFS_DATA = 3'h0;
	localparam logic [2:0] OFS_FEATURE = 3'h1;
	localparam logic [2:0] OFS_COUNT = 3'h2;
	localparam logic [2:0] OFS_ADDR_LO = 3'h3;
	localparam logic [2:0] OFS_ADDR_MID = 3'h4;
	localparam logic [2:0] OFS_ADDR_HI = 3'h5;
	localparam logic [2:0] OFS_DEVICE = 3'h6;
	localparam logic [2:0] OFS_COMMAND = 3'h7;
	// ==========================================
	// command opcodes
	localparam logic [7:0] CMD_SET_MULTI = 8'hC6;
	localparam logic [7:0] CMD_SLEEP = 8'hE6;
	localparam logic [7:0] CMD_STANDBY = 8'hE2;
	localparam logic [7:0] CMD_STANDBY_NOW = 8'hE0;
	localparam logic [7:0] CMD_WRITE_BUF = 8'hE8;
	localparam logic [7:0] CMD_WRITE_DMA = 8'hCA;
	localparam logic [7:0] CMD_WRITE_MULTI = 8'hC5;
	// ==========================================
	// status and error bit positions
	localparam int ST_BSY = 7;
	localparam int ST_DRDY = 6;
	localparam int ST_DF = 5;
	localparam int ST_DRQ = 3;
	localparam int ST_ERR = 0;
	localparam int ER_IDNF = 4;
	localparam int ER_ABRT = 2;
	// ==========================================
	// sizes and reset values
	localparam logic [7:0] LAST_WORD = 8'hFF;
	localparam logic [8:0] FULL_COUNT = 9'h100;
	localparam logic [7:0] BLOCK_MAX = 8'h10;
	localparam logic [7:0] MULTI_RST = 8'h00;
	localparam logic [7:0] ERROR_RST = 8'h00;
	// ==========================================
	// idle timer
	localparam int IDLE_TIME_US = 5000;
	localparam int CLK_MHZ = 20;
	localparam int IDLE_CYCLES = IDLE_TIME_US * CLK_MHZ;
	// ==========================================
	typedef enum logic [2:0] {
		ST_IDLE, ST_EXEC, ST_PIO_IN, ST_DMA_IN, ST_COMMIT, ST_WAIT
	} atw_state_t;
endpackage

/* File: verification/atw_host_model.sv */
`timescale 1ns/100ps
module atw_host_model (
	// clock
	input wire logic core_clk_i,
	// device answer
	input wire logic [15:0] rdata_i,
	input wire logic rdata_oe_i,
	// host pins
	output logic cs0_n_o,
	output logic [2:0] addr_o,
	output logic iord_n_o,
	output logic iowr_n_o,
	output logic dmack_n_o,
	output logic [15:0] wdata_o
);
	// ==========================================
	// idle levels
	initial begin
		cs0_n_o = 1'b1;
		addr_o = 3'h0;
		iord_n_o = 1'b1;
		iowr_n_o = 1'b1;
		dmack_n_o = 1'b1;
		wdata_o = 16'hA5A5;
	end
	// ==========================================
	// strobe cycles
	task automatic step(int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	// released bus shows the inverse so stale data cannot pass for a match
	task automatic strobe(logic [15:0] d);
		wdata_o = d;
		step(1);
		iowr_n_o = 1'b0;
		step(3);
		iowr_n_o = 1'b1;
		step(4);
		wdata_o = ~d;
	endtask
	// a clock edge passes before the next transfer may drive the pins again
	task automatic wr(logic [2:0] a, logic [15:0] d);
		cs0_n_o = 1'b0;
		addr_o = a;
		strobe(d);
		cs0_n_o = 1'b1;
		step(1);
	endtask
	task automatic dw(logic [15:0] d);
		dmack_n_o = 1'b0;
		strobe(d);
		step(1);
	endtask
	task automatic dma_end();
		dmack_n_o = 1'b1;
	endtask
	task automatic rd(logic [2:0] a, output logic [15:0] d, output logic oe);
		cs0_n_o = 1'b0;
		addr_o = a;
		step(1);
		iord_n_o = 1'b0;
		step(5);
		d = rdata_i;
		oe = rdata_oe_i;
		iord_n_o = 1'b1;
		step(1);
		cs0_n_o = 1'b1;
		step(3);
	endtask
endmodule // atw_host_model

/* File: verification/tb_atw_core.sv */
`timescale 1ns/100ps
module tb_atw_core;
	import atw_pkg::*;
	// ==========================================
	// signals
	localparam int IDLE = 50;
	localparam int LIMIT = 90000;
	// expected status and error images, built from the bit positions
	localparam logic [7:0] S_RDY = 8'(1 << ST_DRDY);
	localparam logic [7:0] S_DRQ = S_RDY | 8'(1 << ST_DRQ);
	localparam logic [7:0] S_ERR = S_RDY | 8'(1 << ST_ERR);
	localparam logic [7:0] S_FLT = S_ERR | 8'(1 << ST_DF);
	localparam logic [7:0] E_ABRT = 8'(1 << ER_ABRT);
	localparam logic [7:0] E_IDNF = 8'(1 << ER_IDNF);
	logic core_clk_i, resetn_i, cs0_n, iord_n, iowr_n, dmack_n, oe, dmarq, intrq, sleep;
	logic soft_reset, revert_off, eight_bit, crc_err, mreq, mdone, merr, mfault, irq_q, fault_on;
	logic [2:0] addr;
	logic [7:0] rd_addr;
	logic [15:0] wdata, rdata, rd_word;
	logic [27:0] capacity, mlba, err_lba;
	logic [27:0] mq[$];
	logic [15:0] buf_m[256];
	logic mpend = 1'b0;
	int miscompares, total_checks, irq_cnt, cyc, mdly;
	atw_core #(.IDLE_COUNT(IDLE)) atw_core_inst (
		.core_clk_i(core_clk_i), .resetn_i(resetn_i), .cs0_n_i(cs0_n), .addr_i(addr),
		.iord_n_i(iord_n), .iowr_n_i(iowr_n), .dmack_n_i(dmack_n), .data_i(wdata),
		.data_o(rdata), .data_oe_o(oe), .dmarq_o(dmarq), .intrq_o(intrq),
		.soft_reset_i(soft_reset), .revert_off_i(revert_off), .eight_bit_i(eight_bit),
		.crc_err_i(crc_err), .capacity_i(capacity), .media_req_o(mreq), .media_lba_o(mlba),
		.media_done_i(mdone), .media_err_i(merr), .media_fault_i(mfault),
		.media_rd_addr_i(rd_addr), .media_rd_data_o(rd_word), .sleep_o(sleep)
	);
	atw_host_model atw_host_model_inst (
		.core_clk_i(core_clk_i), .rdata_i(rdata), .rdata_oe_i(oe), .cs0_n_o(cs0_n),
		.addr_o(addr), .iord_n_o(iord_n), .iowr_n_o(iowr_n), .dmack_n_o(dmack_n), .wdata_o(wdata)
	);
	initial begin
		core_clk_i = 1'b0;
		forever #25 core_clk_i = ~core_clk_i;
	end
	// ==========================================
	// media back end with random latency; fails the sector at err_lba
	always @(posedge core_clk_i) begin
		mdone <= #1 mpend && mdly == 0 && mreq !== 1'b1;
		merr <= #1 mq.size() > 0 && mq[$] === err_lba && !fault_on;
		mfault <= #1 mq.size() > 0 && mq[$] === err_lba && fault_on;
		if (mreq === 1'b1) begin
			mq.push_back(mlba);
			mdly <= $urandom % 6;
			mpend <= 1'b1;
		end else if (mpend && mdly == 0) begin
			mpend <= 1'b0;
		end else if (mpend) begin
			mdly <= mdly - 1;
		end
	end
	always @(posedge core_clk_i) begin
		irq_q <= intrq;
		if (intrq === 1'b1 && irq_q !== 1'b1) irq_cnt++;
		cyc++;
		if (cyc == LIMIT) begin
			miscompares++;
			conclude();
		end
	end
	// ==========================================
	// checks
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic cmp(logic [31:0] g, logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk_reg(logic [15:0] g, logic [15:0] e);
		cmp({16'h0000, g}, {16'h0000, e});
	endtask
	task automatic chk_flag(logic g, logic e);
		cmp({31'h0, g}, {31'h0, e});
	endtask
	task automatic chk_lba(logic [27:0] g, logic [27:0] e);
		cmp({4'h0, g}, {4'h0, e});
	endtask
	task automatic step(int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task automatic rdchk(logic [2:0] a, logic [7:0] e);
		logic [15:0] d;
		logic o;
		atw_host_model_inst.rd(a, d, o);
		chk_flag(o, 1'b1);
		chk_reg({8'h00, d[7:0]}, {8'h00, e});
	endtask
	task automatic wait_irq();
		for (int i = 0; i < 30000 && intrq !== 1'b1; i++) step(1);
		chk_flag(intrq, 1'b1);
	endtask
	task automatic finish(logic [7:0] st, logic [7:0] er);
		wait_irq();
		rdchk(OFS_COMMAND, st);
		rdchk(OFS_FEATURE, er);
	endtask
	// ==========================================
	// command sequences
	task automatic issue(logic [7:0] c, logic [7:0] n, logic [27:0] l);
		atw_host_model_inst.wr(OFS_COUNT, {8'h00, n});
		atw_host_model_inst.wr(OFS_ADDR_LO, {8'h00, l[7:0]});
		atw_host_model_inst.wr(OFS_ADDR_MID, {8'h00, l[15:8]});
		atw_host_model_inst.wr(OFS_ADDR_HI, {8'h00, l[23:16]});
		atw_host_model_inst.wr(OFS_DEVICE, {8'h00, 4'hE, l[27:24]});
		irq_cnt = 0;
		mq.delete();
		atw_host_model_inst.wr(OFS_COMMAND, {8'h00, c});
	endtask
	task automatic setm(int n, logic [7:0] st, logic [7:0] er);
		issue(CMD_SET_MULTI, 8'(n), 28'h0);
		finish(st, er);
	endtask
	task automatic lba_chk(logic [27:0] l, int n);
		rdchk(OFS_ADDR_LO, l[7:0]);
		rdchk(OFS_ADDR_MID, l[15:8]);
		rdchk(OFS_ADDR_HI, l[23:16]);
		chk_reg(16'(mq.size()), 16'(n));
		for (int i = 0; i < n; i++) chk_lba(mq[i], l - 28'(n) + 28'(i) + 28'h1);
	endtask
	task automatic pio(int n);
		logic [15:0] w;
		logic [15:0] s;
		logic o;
		for (int i = 0; i < n; i++) begin
			// only one sector is buffered: wait for DRQ before the next sector
			s = 16'h0000;
			for (int j = 0; j < 50 && i % 256 == 0 && i > 0
				&& s[ST_DRQ] !== 1'b1; j++) begin
				atw_host_model_inst.rd(OFS_COMMAND, s, o);
			end
			w = 16'($urandom);
			buf_m[i % 256] = w;
			atw_host_model_inst.wr(OFS_DATA, w);
		end
	endtask
	task automatic wmulti(int n, int blk, logic [27:0] l, int eo);
		int done;
		int bl;
		done = 0;
		issue(CMD_WRITE_MULTI, 8'(n), l);
		while (done < n) begin
			bl = (n - done < blk) ? n - done : blk;
			wait_irq();
			rdchk(OFS_COMMAND, S_DRQ);
			pio(bl * 256);
			if (eo >= done && eo < done + bl) break;
			done += bl;
		end
		if (eo >= 0) begin
			finish(fault_on ? S_FLT : S_ERR, E_ABRT);
			lba_chk(l + 28'(eo), eo + 1);
		end else begin
			finish(S_RDY, 8'h00);
			lba_chk(l + 28'(n) - 28'h1, n);
		end
	endtask
	task automatic dma(int n, logic [27:0] l, logic [7:0] st, logic [7:0] er, int crc_at, int ns);
		issue(CMD_WRITE_DMA, 8'(n), l);
		for (int i = 0; i < n * 256; i++) begin
			for (int j = 0; j < 30000 && dmarq !== 1'b1 && intrq !== 1'b1; j++) step(1);
			if (intrq === 1'b1) break;
			chk_flag(dmarq, 1'b1);
			if (i == crc_at) begin
				crc_err = 1'b1;
				step(1);
				crc_err = 1'b0;
				step(6);
			end else begin
				atw_host_model_inst.dw(16'($urandom));
			end
		end
		atw_host_model_inst.dma_end();
		finish(st, er);
		chk_reg(16'(irq_cnt), 16'h0001);
		lba_chk(ns == 0 ? l : l + 28'(ns) - 28'h1, ns);
	endtask
	// ==========================================
	// main sequence
	initial begin
		logic [27:0] lv;
		logic [7:0] cmds[3];
		void'($urandom(36024));
		cmds = '{CMD_SLEEP, CMD_STANDBY, CMD_STANDBY_NOW};
		resetn_i = 1'b0;
		{soft_reset, revert_off, eight_bit, crc_err, fault_on} = 5'h00;
		capacity = 28'h0100000;
		err_lba = 28'hFFFFFFF;
		rd_addr = 8'h00;
		step(8);
		resetn_i = 1'b1;
		step(6);
		lv = 28'($urandom % 32'h000F0000);
		rdchk(OFS_COMMAND, S_RDY);
		issue(CMD_WRITE_MULTI, 8'h01, lv);
		finish(S_ERR, E_ABRT);
		for (int k = 1; k <= 16; k *= 2) setm(k, S_RDY, 8'h00);
		setm(4, S_RDY, 8'h00);
		setm(3, S_ERR, E_ABRT);
		wmulti(6, 4, lv, -1);
		setm(2, S_RDY, 8'h00);
		err_lba = lv + 28'h1;
		wmulti(3, 2, lv, 1);
		fault_on = 1'b1;
		err_lba = lv;
		wmulti(3, 2, lv, 0);
		{fault_on, err_lba} = {1'b0, 28'hFFFFFFF};
		capacity = 28'h0000400;
		issue(CMD_WRITE_MULTI, 8'h02, 28'h00003FF);
		finish(S_ERR, E_IDNF);
		capacity = 28'h0100000;
		revert_off = 1'b1;
		soft_reset = 1'b1;
		step(1);
		soft_reset = 1'b0;
		wmulti(1, 2, lv, -1);
		setm(0, S_RDY, 8'h00);
		issue(CMD_WRITE_MULTI, 8'h01, lv);
		finish(S_ERR, E_ABRT);
		setm(2, S_RDY, 8'h00);
		revert_off = 1'b0;
		soft_reset = 1'b1;
		step(1);
		soft_reset = 1'b0;
		issue(CMD_WRITE_MULTI, 8'h01, lv);
		finish(S_ERR, E_ABRT);
		eight_bit = 1'b1;
		dma(1, lv, S_ERR, E_ABRT, -1, 0);
		eight_bit = 1'b0;
		dma(2, lv, S_RDY, 8'h00, -1, 2);
		dma(1, lv, S_ERR, E_ABRT, 10, 0);
		err_lba = lv + 28'h1;
		dma(2, lv, S_ERR, E_ABRT, -1, 2);
		err_lba = 28'hFFFFFFF;
		issue(CMD_WRITE_BUF, 8'h00, 28'h0);
		step(12);
		rdchk(OFS_COMMAND, S_DRQ);
		pio(256);
		finish(S_RDY, 8'h00);
		chk_reg(16'(mq.size()), 16'h0000);
		for (int k = 0; k < 4; k++) begin
			rd_addr = 8'($urandom);
			step(2);
			chk_reg(rd_word, buf_m[rd_addr]);
		end
		foreach (cmds[k]) begin
			issue(cmds[k], 8'h00, 28'h0);
			finish(S_RDY, 8'h00);
			chk_flag(sleep, 1'b1);
			setm(1, S_RDY, 8'h00);
			chk_flag(sleep, 1'b0);
		end
		step(IDLE + 10);
		chk_flag(sleep, 1'b1);
		conclude();
	end
endmodule // tb_atw_core
